/* File: sgbs_pkg.sv */
/*
 * Constants and types for the spare GPIO and boot strap block: bus map,
 * field positions, serial command encoding, frame timing.
 * Assumes a single 100 MHz clock and a synchronous active-low reset.
 */
// Behaviour
// - six spare pins controlled by serial commands
// - reset: all pins input, weak pull-up
// - pin drives only after explicit output command
// - input pull: weak, strong or none
// - input without pull is high impedance
// - strap high at reset release selects boot
// - strap free during reset, taken at release
// - boot mode passes data, no pin commands
// - serial link 8N1, 9600 baud default
package sgbs_pkg;

    localparam int SGBS_CLK_HZ    = 100_000_000;
    localparam int SGBS_BAUD      = 9600;
    localparam int SGBS_NUM_PINS  = 6;
    localparam int SGBS_DATA_BITS = 8;

    // bus map, byte addresses
    localparam logic [3:0] SGBS_ADDR_CTRL   = 4'h0;
    localparam logic [3:0] SGBS_ADDR_STATUS = 4'h4;
    localparam logic [3:0] SGBS_ADDR_PULL   = 4'h8;

    // status fields
    localparam int SGBS_ST_LEVEL  = 0;
    localparam int SGBS_ST_DRIVE  = 8;
    localparam int SGBS_ST_BOOT   = 16;
    localparam int SGBS_ST_FRERR  = 17;
    localparam int SGBS_ST_TXBUSY = 18;
    // pull register fields
    localparam int SGBS_PL_WEAK   = 0;
    localparam int SGBS_PL_STRONG = 8;
    localparam int SGBS_PL_OUTLVL = 16;

    // command byte: opcode high nibble, pin number low nibble
    localparam logic [3:0] SGBS_OP_IN_WEAK   = 4'h1;
    localparam logic [3:0] SGBS_OP_IN_STRONG = 4'h2;
    localparam logic [3:0] SGBS_OP_IN_NOPULL = 4'h3;
    localparam logic [3:0] SGBS_OP_OUT_LOW   = 4'h4;
    localparam logic [3:0] SGBS_OP_OUT_HIGH  = 4'h5;
    localparam logic [3:0] SGBS_OP_READ      = 4'h6;
    localparam logic [7:0] SGBS_REPLY_BASE   = 8'h30;

    typedef struct packed {
        logic [3:0] op;
        logic [3:0] pin;
    } sgbs_cmd_t;

    typedef enum {SGBS_RX_IDLE, SGBS_RX_START, SGBS_RX_DATA, SGBS_RX_STOP} sgbs_rx_state_t;
    typedef enum {SGBS_TX_IDLE, SGBS_TX_START, SGBS_TX_DATA, SGBS_TX_STOP} sgbs_tx_state_t;

endpackage : sgbs_pkg

/* File: sgbs_spare_gpio.sv */
/*
 * Spare GPIO pins commanded over an 8N1 serial link, boot strap capture,
 * and an Avalon-MM register slave with waitrequest.
 * Assumes pin and serial inputs are synchronous to clock.
 */
// Implementation choices: the register offsets and the Avalon-MM register port.
module sgbs_spare_gpio
    import sgbs_pkg::*;
#(
    parameter int BAUD_DIV = SGBS_CLK_HZ / SGBS_BAUD
) (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    // avalon-mm slave
    input  wire logic [3:0]               address,
    input  wire logic                     read,
    input  wire logic                     write,
    input  wire logic [3:0]               byteenable,
    input  wire logic [31:0]              writedata,
    output logic      [31:0]              readdata,
    output logic                          waitrequest,
    // serial command link
    input  wire logic                     rxLine,
    output logic                          txLine,
    // spare pins
    input  wire logic [SGBS_NUM_PINS-1:0] spare_pins_in,
    output logic      [SGBS_NUM_PINS-1:0] spare_pins_out,
    output logic      [SGBS_NUM_PINS-1:0] spare_pins_oe,
    output logic      [SGBS_NUM_PINS-1:0] spare_pins_weak_pu,
    output logic      [SGBS_NUM_PINS-1:0] spare_pins_strong_pu,
    // boot selection and loader data
    input  wire logic                     boot_select_strap,
    output logic                          bootMode,
    output logic      [7:0]               bootData,
    output logic                          bootDataValid
);

    localparam logic [15:0] BAUD_DIV_W = 16'(BAUD_DIV);
    localparam logic [15:0] ONE16      = 16'h0001;

    logic [15:0]    baudDiv;
    logic           strapTaken;
    logic           frameErr;
    sgbs_rx_state_t rxState;
    logic [15:0]    rxCnt;
    logic [2:0]     rxBit;
    logic [7:0]     rxShift;
    logic           cmdValid;
    sgbs_cmd_t      cmd;
    sgbs_tx_state_t txState;
    logic [15:0]    txCnt;
    logic [2:0]     txBit;
    logic [7:0]     txShift;
    logic           busReq;
    logic           busAck;
    logic           pinCmd;
    logic           readReq;
    logic           pinLevel;
    logic [31:0]    next_readdata;

    assign busReq   = read | write;
    assign busAck   = busReq & ~waitrequest;
    assign pinCmd   = cmdValid & ~bootMode & (cmd.pin < 4'(SGBS_NUM_PINS));
    assign readReq  = pinCmd & (cmd.op == SGBS_OP_READ);
    assign pinLevel = spare_pins_in[cmd.pin[2:0]];

    // strap is ignored while held in reset and caught once on release
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            strapTaken <= 1'b0;
            bootMode   <= 1'b0;
        end else if (!strapTaken) begin
            strapTaken <= 1'b1;
            bootMode   <= boot_select_strap;
        end
    end

    // serial receiver, samples mid-bit
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rxState  <= SGBS_RX_IDLE;
            rxCnt    <= 16'h0000;
            rxBit    <= 3'h0;
            rxShift  <= 8'h00;
            cmdValid <= 1'b0;
        end else begin
            cmdValid <= 1'b0;
            case (rxState)
                SGBS_RX_IDLE: begin
                    if (!rxLine) begin
                        rxState <= SGBS_RX_START;
                        rxCnt   <= baudDiv >> 1;
                    end
                end
                SGBS_RX_START: begin
                    if (rxCnt != 16'h0000) begin
                        rxCnt <= rxCnt - ONE16;
                    end else if (!rxLine) begin
                        rxState <= SGBS_RX_DATA;
                        rxCnt   <= baudDiv - ONE16;
                        rxBit   <= 3'h0;
                    end else begin
                        rxState <= SGBS_RX_IDLE; // glitch, not a start bit
                    end
                end
                SGBS_RX_DATA: begin
                    if (rxCnt != 16'h0000) begin
                        rxCnt <= rxCnt - ONE16;
                    end else begin
                        rxShift <= {rxLine, rxShift[7:1]};
                        rxCnt   <= baudDiv - ONE16;
                        rxBit   <= rxBit + 3'h1;
                        if (rxBit == 3'(SGBS_DATA_BITS - 1)) begin
                            rxState <= SGBS_RX_STOP;
                        end
                    end
                end
                SGBS_RX_STOP: begin
                    if (rxCnt != 16'h0000) begin
                        rxCnt <= rxCnt - ONE16;
                    end else begin
                        rxState  <= SGBS_RX_IDLE;
                        cmdValid <= rxLine;
                    end
                end
                default: rxState <= SGBS_RX_IDLE;
            endcase
        end
    end

    assign cmd = sgbs_cmd_t'(rxShift);

    // boot loader gets raw bytes instead of pin commands
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bootData      <= 8'h00;
            bootDataValid <= 1'b0;
        end else begin
            bootDataValid <= cmdValid & bootMode;
            if (cmdValid && bootMode) begin
                bootData <= rxShift;
            end
        end
    end

    // per-pin configuration, only the addressed pin moves
    for (genvar i = 0; i < SGBS_NUM_PINS; i++) begin : g_pin
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                spare_pins_oe[i]        <= 1'b0;
                spare_pins_out[i]       <= 1'b0;
                spare_pins_weak_pu[i]   <= 1'b1;
                spare_pins_strong_pu[i] <= 1'b0;
            end else if (pinCmd && cmd.pin == 4'(i)) begin
                case (cmd.op)
                    SGBS_OP_IN_WEAK: begin
                        spare_pins_oe[i]        <= 1'b0;
                        spare_pins_weak_pu[i]   <= 1'b1;
                        spare_pins_strong_pu[i] <= 1'b0;
                    end
                    SGBS_OP_IN_STRONG: begin
                        spare_pins_oe[i]        <= 1'b0;
                        spare_pins_weak_pu[i]   <= 1'b0;
                        spare_pins_strong_pu[i] <= 1'b1;
                    end
                    SGBS_OP_IN_NOPULL: begin
                        spare_pins_oe[i]        <= 1'b0;
                        spare_pins_weak_pu[i]   <= 1'b0;
                        spare_pins_strong_pu[i] <= 1'b0;
                    end
                    SGBS_OP_OUT_LOW, SGBS_OP_OUT_HIGH: begin
                        spare_pins_oe[i]        <= 1'b1;
                        spare_pins_out[i]       <= (cmd.op == SGBS_OP_OUT_HIGH);
                        spare_pins_weak_pu[i]   <= 1'b0;
                        spare_pins_strong_pu[i] <= 1'b0;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // reply transmitter; a read while busy is dropped, no queue kept
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            txState <= SGBS_TX_IDLE;
            txCnt   <= 16'h0000;
            txBit   <= 3'h0;
            txShift <= 8'h00;
            txLine  <= 1'b1;
        end else begin
            case (txState)
                SGBS_TX_IDLE: begin
                    txLine <= 1'b1;
                    if (readReq) begin
                        txShift <= SGBS_REPLY_BASE | {7'h00, pinLevel};
                        txState <= SGBS_TX_START;
                        txCnt   <= baudDiv - ONE16;
                        txLine  <= 1'b0;
                    end
                end
                SGBS_TX_START: begin
                    if (txCnt != 16'h0000) begin
                        txCnt <= txCnt - ONE16;
                    end else begin
                        txState <= SGBS_TX_DATA;
                        txCnt   <= baudDiv - ONE16;
                        txBit   <= 3'h0;
                        txLine  <= txShift[0];
                    end
                end
                SGBS_TX_DATA: begin
                    if (txCnt != 16'h0000) begin
                        txCnt <= txCnt - ONE16;
                    end else begin
                        txCnt   <= baudDiv - ONE16;
                        txBit   <= txBit + 3'h1;
                        if (txBit == 3'(SGBS_DATA_BITS - 1)) begin
                            txState <= SGBS_TX_STOP;
                            txLine  <= 1'b1;
                        end else begin
                            txLine  <= txShift[txBit + 3'h1];
                        end
                    end
                end
                SGBS_TX_STOP: begin
                    if (txCnt != 16'h0000) begin
                        txCnt <= txCnt - ONE16;
                    end else begin
                        txState <= SGBS_TX_IDLE;
                    end
                end
                default: txState <= SGBS_TX_IDLE;
            endcase
        end
    end

    // one wait cycle per access, answer on the following edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= ~(busReq & waitrequest);
        end
    end

    // divisor; zero is refused since baudDiv - 1 would wrap the bit timer reloads to 16'hFFFF
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            baudDiv <= BAUD_DIV_W;
        end else if (busAck && write && address == SGBS_ADDR_CTRL) begin
            if ({byteenable[1] ? writedata[15:8] : baudDiv[15:8],
                 byteenable[0] ? writedata[7:0]  : baudDiv[7:0]} != 16'h0000) begin
                baudDiv <= {byteenable[1] ? writedata[15:8] : baudDiv[15:8],
                            byteenable[0] ? writedata[7:0]  : baudDiv[7:0]};
            end
        end
    end

    // framing error sticky, write one to clear, a new error wins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            frameErr <= 1'b0;
        end else if (rxState == SGBS_RX_STOP && rxCnt == 16'h0000 && !rxLine) begin
            frameErr <= 1'b1;
        end else if (busAck && write && address == SGBS_ADDR_STATUS
                     && byteenable[2] && writedata[SGBS_ST_FRERR]) begin
            frameErr <= 1'b0;
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        case (address)
            SGBS_ADDR_CTRL: next_readdata[15:0] = baudDiv;
            SGBS_ADDR_STATUS: begin
                next_readdata[SGBS_ST_LEVEL +: SGBS_NUM_PINS] = spare_pins_in;
                next_readdata[SGBS_ST_DRIVE +: SGBS_NUM_PINS] = spare_pins_oe;
                next_readdata[SGBS_ST_BOOT]                   = bootMode;
                next_readdata[SGBS_ST_FRERR]                  = frameErr;
                next_readdata[SGBS_ST_TXBUSY]                 = (txState != SGBS_TX_IDLE);
            end
            SGBS_ADDR_PULL: begin
                next_readdata[SGBS_PL_WEAK   +: SGBS_NUM_PINS] = spare_pins_weak_pu;
                next_readdata[SGBS_PL_STRONG +: SGBS_NUM_PINS] = spare_pins_strong_pu;
                next_readdata[SGBS_PL_OUTLVL +: SGBS_NUM_PINS] = spare_pins_out;
            end
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            readdata <= next_readdata;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_release;
        $rose(rst_n);
    endsequence
    sequence s_pin_cmd(logic [3:0] op);
        pinCmd && cmd.op == op;
    endsequence

    a_reset_pin_state: assert property (s_release |-> spare_pins_oe == '0
        && spare_pins_weak_pu == '1 && spare_pins_strong_pu == '0)
        else $error("pins not input with weak pull-up after reset");
    a_drive_needs_cmd: assert property ((spare_pins_oe & ~$past(spare_pins_oe)) != '0
        |-> $past(pinCmd) && ($past(cmd.op) == SGBS_OP_OUT_LOW
        || $past(cmd.op) == SGBS_OP_OUT_HIGH))
        else $error("pin began to drive without output command");
    a_pull_exclusive: assert property ((spare_pins_weak_pu & spare_pins_strong_pu) == '0
        && (spare_pins_oe & (spare_pins_weak_pu | spare_pins_strong_pu)) == '0)
        else $error("conflicting pull or drive setting");
    a_nopull_hiz: assert property (s_pin_cmd(SGBS_OP_IN_NOPULL) |=>
        !spare_pins_oe[$past(cmd.pin[2:0])] && !spare_pins_weak_pu[$past(cmd.pin[2:0])]
        && !spare_pins_strong_pu[$past(cmd.pin[2:0])])
        else $error("no-pull input not high impedance");
    a_boot_capture: assert property (s_release |=> bootMode == $past(boot_select_strap))
        else $error("boot mode not taken from strap at release");
    a_boot_hold: assert property (strapTaken |=> $stable(bootMode))
        else $error("boot mode changed while running");
    a_boot_no_pins: assert property (cmdValid && bootMode |=> bootDataValid
        && $stable(spare_pins_oe) && $stable(spare_pins_out) && txState == $past(txState))
        else $error("pin command handled in boot mode");
    a_tx_stop_high: assert property (txState == SGBS_TX_STOP || txState == SGBS_TX_IDLE
        ##0 !readReq |-> txLine)
        else $error("serial line low outside a frame");
    a_read_reply: assert property (readReq && txState == SGBS_TX_IDLE |=>
        txState == SGBS_TX_START && !txLine && txShift[0] == $past(pinLevel))
        else $error("read reply missing or wrong level");
    a_others_kept: assert property (pinCmd |=>
        ((spare_pins_oe ^ $past(spare_pins_oe))
        & ~(6'h01 << $past(cmd.pin[2:0]))) == '0)
        else $error("command changed another pin");
    a_bus_answer: assert property (busReq && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus access not answered in one cycle");

endmodule : sgbs_spare_gpio

/* File: sgbs_host_model.sv */
/*
 * Host-side serial partner: sends 8N1 command bytes to the block and
 * collects its replies. Assumes a bit time of BIT clock cycles.
 */
module sgbs_host_model #(
    parameter int BIT = 16
) (
    // clock
    input  wire logic clock,
    // serial link
    output logic      hostTx,
    input  wire logic txLine
);
    timeunit 1ns;
    timeprecision 1ns;

    initial hostTx = 1'b1;

    // low stop level only when a scenario wants a framing fault
    task automatic send_byte(input logic [7:0] b, input logic stopLvl);
        logic [9:0] f;
        f = {stopLvl, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            hostTx <= f[i];
            repeat (BIT) @(posedge clock);
        end
        hostTx <= 1'b1;
    endtask : send_byte

    // bounded wait for the start bit, then mid-bit sampling
    task automatic get_reply(output logic [7:0] b, output bit ok);
        int n;
        n = 0;
        b = 8'h00;
        while (txLine !== 1'b0 && n < 40 * BIT) begin
            @(posedge clock);
            n++;
        end
        ok = (n < 40 * BIT);
        repeat (BIT / 2) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clock);
            b[i] = txLine;
        end
        repeat (BIT) @(posedge clock);
        ok = ok && (txLine === 1'b1);
    endtask : get_reply
endmodule : sgbs_host_model

/* File: spare_gpio_and_boot_strap_tb_top.sv */
/*
 * Self-checking bench for the spare GPIO block: serial commands, replies,
 * register reads and boot strap capture against an integer model.
 * Assumes sgbs_pkg and the host model are compiled first.
 */
module spare_gpio_and_boot_strap_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sgbs_pkg::*;
    localparam int BIT = 16;

    logic        clock, rst_n, read, write, waitrequest, rxLine, txLine;
    logic        strap, bootMode, bootDataValid;
    logic [3:0]  address, byteenable;
    logic [31:0] writedata, readdata, q;
    logic [5:0]  pinsIn, pinsOut, pinsOe, pinsWeak, pinsStrong;
    logic [7:0]  bootData, lastBoot, rb;
    bit          ok;
    int          miscompares, cmp_count, bootCnt, mOe, mOut, mWeak, mStrong, n;

    sgbs_spare_gpio #(.BAUD_DIV(BIT)) sgbs_spare_gpio_inst (
        .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .rxLine(rxLine), .txLine(txLine),
        .spare_pins_in(pinsIn), .spare_pins_out(pinsOut), .spare_pins_oe(pinsOe),
        .spare_pins_weak_pu(pinsWeak), .spare_pins_strong_pu(pinsStrong),
        .boot_select_strap(strap), .bootMode(bootMode), .bootData(bootData),
        .bootDataValid(bootDataValid));

    sgbs_host_model #(.BIT(BIT)) sgbs_host_model_inst (
        .clock(clock), .hostTx(rxLine), .txLine(txLine));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        if (bootDataValid === 1'b1) begin
            bootCnt++;
            lastBoot = bootData;
        end
    end

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int k;
        k = 0;
        address <= a;
        writedata <= d;
        byteenable <= 4'hF;
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge clock);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        // one idle edge so a following call never re-drives the strobes in this step
        @(posedge clock);
        if (k >= 50) chk("waitrequest", 32'h1, 32'h0);
    endtask : bus

    // strap moves only while reset is held
    task automatic do_reset(input logic s);
        rst_n <= 1'b0;
        strap <= ~s;
        repeat (2) @(posedge clock);
        strap <= s;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        mOe = 0;
        mOut = 0;
        mWeak = 'h3F;
        mStrong = 0;
    endtask : do_reset

    task automatic chk_pins();
        chk("oe", {26'h0, pinsOe}, mOe);
        chk("weak", {26'h0, pinsWeak}, mWeak);
        chk("strong", {26'h0, pinsStrong}, mStrong);
        chk("out", {26'h0, pinsOut & pinsOe}, mOut & mOe);
    endtask : chk_pins

    task automatic cmd(input int op, input int pin);
        int m;
        m = 1 << pin;
        sgbs_host_model_inst.send_byte({op[3:0], pin[3:0]}, 1'b1);
        repeat (4) @(posedge clock);
        // unknown opcodes and pins above five leave every pin as it was
        if (pin < SGBS_NUM_PINS && op >= 1 && op <= 5) begin
            mOe = (op >= 4) ? (mOe | m) : (mOe & ~m);
            mWeak = (op == 1) ? (mWeak | m) : (mWeak & ~m);
            mStrong = (op == 2) ? (mStrong | m) : (mStrong & ~m);
            if (op == 4) mOut = mOut & ~m;
            if (op == 5) mOut = mOut | m;
        end
    endtask : cmd

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (40000) @(posedge clock);
        miscompares++;
        $display("[FAIL] watchdog expected finish seen timeout");
        test_done();
    end

    initial begin
        rst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        byteenable = 4'h0;
        writedata = 32'h0;
        pinsIn = 6'h00;
        strap = 1'b0;
        miscompares = 0;
        cmp_count = 0;
        bootCnt = 0;
        void'($urandom(99683));
        do_reset(1'b0);
        chk_pins();
        chk("bootMode", {31'h0, bootMode}, 32'h0);
        $display("test reset done");
        for (int op = 1; op <= 5; op++) begin
            for (int p = 0; p < 6; p++) begin
                cmd(op, p);
                chk_pins();
            end
        end
        for (int i = 0; i < 20; i++) begin
            cmd(1 + $urandom % 5, $urandom % 8);
            chk_pins();
        end
        cmd(0, 1);
        chk_pins();
        cmd(7, 2);
        chk_pins();
        $display("test pin commands done");
        for (int i = 0; i < 6; i++) begin
            pinsIn <= 6'($urandom);
            @(posedge clock);
            fork
                sgbs_host_model_inst.send_byte(8'h60 | 8'(i), 1'b1);
                sgbs_host_model_inst.get_reply(rb, ok);
            join
            chk("reply", {24'h0, rb}, 32'h30 | ((pinsIn >> i) & 1));
            chk("replyStop", {31'h0, ok}, 32'h1);
        end
        $display("test pin reads done");
        bus(1'b0, SGBS_ADDR_STATUS, 32'h0, q);
        chk("status", q & 32'h0001_3F3F, (mOe << 8) | pinsIn);
        bus(1'b0, SGBS_ADDR_PULL, 32'h0, q);
        chk("pull", q & 32'h003F_3F3F, (mOut << 16) | (mStrong << 8) | mWeak);
        bus(1'b0, 4'hC, 32'h0, q);
        chk("unmapped", q, 32'h0);
        bus(1'b0, SGBS_ADDR_CTRL, 32'h0, q);
        chk("baudDiv", q, BIT);
        bus(1'b1, SGBS_ADDR_CTRL, 32'h0, q);
        bus(1'b0, SGBS_ADDR_CTRL, 32'h0, q);
        chk("baudDivZero", q, BIT);
        $display("test registers done");
        sgbs_host_model_inst.send_byte(8'h41, 1'b0);
        repeat (BIT) @(posedge clock);
        chk_pins();
        bus(1'b0, SGBS_ADDR_STATUS, 32'h0, q);
        chk("frameErr", q & 32'h0002_0000, 32'h0002_0000);
        bus(1'b1, SGBS_ADDR_STATUS, 32'h0002_0000, q);
        bus(1'b0, SGBS_ADDR_STATUS, 32'h0, q);
        chk("frameClr", q & 32'h0002_0000, 32'h0);
        $display("test framing done");
        do_reset(1'b1);
        chk("bootMode", {31'h0, bootMode}, 32'h1);
        n = bootCnt;
        sgbs_host_model_inst.send_byte(8'h41, 1'b1);
        repeat (4) @(posedge clock);
        chk("bootCount", bootCnt, n + 1);
        chk("bootData", {24'h0, lastBoot}, 32'h41);
        chk_pins();
        bus(1'b0, SGBS_ADDR_STATUS, 32'h0, q);
        chk("statusBoot", q & 32'h0001_0000, 32'h0001_0000);
        do_reset(1'b0);
        chk("bootMode", {31'h0, bootMode}, 32'h0);
        $display("test boot strap done");
        test_done();
    end
endmodule : spare_gpio_and_boot_strap_tb_top
